// *** bench/virt_cap_props.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "virt_cap_regs.vh"
module virt_cap_checker (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic VIRT_OP,
   input wire logic ENTRY_FAIL,
   input wire logic TIMER_EXPIRED
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   sequence rd_taken;
      HSEL && HTRANS[1] && HREADY && !HWRITE;
   endsequence
   sequence wr_taken;
      HSEL && HTRANS[1] && HREADY && HWRITE;
   endsequence
   sequence rd_answer;
      !HREADYOUT ##1 HREADYOUT;
   endsequence
   a_read_one_wait: assert property (rd_taken |=> rd_answer)
      else $error("read wait state wrong");
   a_write_no_wait: assert property (wr_taken |=> HREADYOUT)
      else $error("write stalled");
   a_resp_okay: assert property (HRESP == 1'b0)
      else $error("error response");
   a_rdata_on_answer: assert property (
      $changed(HRDATA) |-> $rose(HREADYOUT))
      else $error("read data moved outside a read");
   a_ready_fall_cause: assert property ($fell(HREADYOUT) |->
      $past(HSEL && HTRANS[1] && !HWRITE)) else $error("stray wait state");
   a_fail_needs_virt: assert property (ENTRY_FAIL |-> VIRT_OP)
      else $error("entry fail outside operation");
   a_virt_by_write: assert property ($changed(VIRT_OP) |->
      $past(HSEL && HTRANS[1] && HREADY && HWRITE, 2) &&
      $past(HADDR[15:2], 2) == `IDX_CTRL) else $error("operation flag moved");
   a_expiry_in_virt: assert property ($rose(TIMER_EXPIRED) |->
      $past(VIRT_OP)) else $error("timer expired outside operation");
endmodule // virt_cap_checker
bind virt_capability_registers virt_cap_checker u_virt_cap_checker (
   .REF_CLK(REF_CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR),
   .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
   .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .VIRT_OP(VIRT_OP), .ENTRY_FAIL(ENTRY_FAIL), .TIMER_EXPIRED(TIMER_EXPIRED));
`default_nettype wire

// *** bench/virt_capability_registers_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "virt_cap_regs.vh"
module virt_capability_registers_bench;
   logic REF_CLK = 1'b0;
   logic RESETN, HSEL, HWRITE;
   logic [31:0] HADDR, HWDATA, HRDATA, rdat, t0;
   logic [1:0] HTRANS;
   logic [2:0] HSIZE;
   logic HREADYOUT, HRESP, VIRT_OP, ENTRY_FAIL, TIMER_EXPIRED;
   logic [63:0] misc_exp, ept_exp, fx_exp;
   int n_errors = 0;
   int check_count = 0;
   // only these page-table/tag bits carry meaning; the rest read zero
   localparam logic [63:0] EPT_DEFINED = 64'h0000_0f01_06f3_4141;
   always #12.5 REF_CLK = ~REF_CLK;
   virt_capability_registers u_virt_capability_registers (
      .REF_CLK(REF_CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
      .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
      .HRESP(HRESP), .VIRT_OP(VIRT_OP), .ENTRY_FAIL(ENTRY_FAIL),
      .TIMER_EXPIRED(TIMER_EXPIRED));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // caller sits just after a rising edge; back to back is allowed
   task bus(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HWRITE <= wr;
      HADDR <= {16'h0000, idx, 2'h0};
      @(posedge REF_CLK);
      while (HREADYOUT !== 1'b1) @(posedge REF_CLK);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      @(posedge REF_CLK);
      while (HREADYOUT !== 1'b1) @(posedge REF_CLK);
      rdat = HRDATA;
   endtask
   task wr(input logic [13:0] idx, input logic [31:0] d);
      bus(1'b1, idx, d);
   endtask
   task rd(input logic [13:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0000_0000);
      chk(rdat, exp);
   endtask
   task rd64(input logic [13:0] idx, input logic [63:0] exp);
      rd(idx, exp[31:0]);
      rd(idx + `IDX_HIGH, exp[63:32]);
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task cap_sweep;
      rd64(`IDX_MISC, misc_exp);
      rd64(`IDX_CR0_F0, `CR0_FIXED0 & `CR0_FIXED1);
      rd64(`IDX_CR0_F1, `CR0_FIXED1);
      rd64(`IDX_CR4_F0, `CR4_FIXED0 & `CR4_FIXED1);
      rd64(`IDX_CR4_F1, `CR4_FIXED1);
      rd64(`IDX_ENUM, {54'h0, `ENUM_MAX_IDX, 1'b0});
      rd64(`IDX_EPT, ept_exp);
   endtask
   initial begin
      repeat (20000) @(posedge REF_CLK);
      n_errors++;
      print_verdict;
   end
   initial begin
      RESETN = 1'b0;
      HSEL = 1'b0;
      HADDR = 32'h0000_0000;
      HTRANS = 2'h0;
      HWRITE = 1'b0;
      HSIZE = 3'h2;
      HWDATA = 32'h0000_0000;
      misc_exp = {`MONITOR_SEGMENT_REV, 1'b0, `CAP_ZERO_LEN_INJ, `CAP_WRITE_ANY,
         `CAP_SMI_HOLD, `MSR_LIST_N, `CR3_TARGETS == 8'h00, `CR3_TARGETS,
         `CAP_SMBASE_READ, `CAP_TRACE, 5'h00, `ACT_STATES,
         `CAP_UNRESTRICTED | `CAP_LMA_STORE, `PREEMPT_RATE};
      ept_exp = `EPT_CAP_RAW & EPT_DEFINED;
      if (!(`CAP_SECONDARY && (`CAP_EPT || `CAP_VIRTUAL_PROCESSOR_TAG))) ept_exp = 64'h0;
      repeat (8) @(posedge REF_CLK);
      RESETN <= 1'b1;
      @(posedge REF_CLK);
      cap_sweep;
      for (int i = 0; i < 4; i += 2) begin
         fx_exp = (i == 0) ? `CR0_FIXED0 & `CR0_FIXED1 :
            `CR4_FIXED0 & `CR4_FIXED1;
         rd(`IDX_CR0_F0 + i, fx_exp[31:0]);
         t0 = rdat;
         bus(1'b0, `IDX_CR0_F1 + i, 32'h0);
         chk(t0 & ~rdat, 32'h0000_0000);
      end
      wr(`IDX_CR0_CAND, 32'hffff_0000);
      wr(`IDX_CR4_CAND, 32'h0000_0f0f);
      rd(`IDX_CR0_OUT, 32'hffff_0000);
      wr(`IDX_TRACE, 32'h0000_0001);
      wr(`IDX_CTRL, 32'h0000_0001);
      rd(`IDX_CR0_OUT, (32'hffff_0000 | `CR0_FIXED0) & `CR0_FIXED1);
      rd(`IDX_CR4_OUT, (32'h0000_0f0f | `CR4_FIXED0) & `CR4_FIXED1);
      rd(`IDX_TRACE, {31'h0, `CAP_TRACE});
      wr(`IDX_TRACE, 32'h0000_0001);
      bus(1'b0, `IDX_STATUS, 32'h0);
      chk(rdat & 32'h1f, {27'h0, 1'b1, ~`CAP_TRACE, 3'h0});
      for (int i = 0; i < 4; i++) begin
         wr(`IDX_CTRL, {29'h0, i[1:0], 1'b1});
         repeat (2) @(posedge REF_CLK);
         chk({31'h0, ENTRY_FAIL},
            i == 0 ? 0 : ~`ACT_STATES >> (i - 1) & 1);
      end
      wr(`IDX_CTRL, 32'h0000_0009);
      wr(`IDX_CTRL, 32'h0000_0008);
      bus(1'b0, `IDX_STATUS, 32'h0);
      chk(rdat & 32'h10, {27'h0, `CAP_SMI_HOLD, 4'h0});
      wr(`IDX_CTRL, 32'h0000_0001);
      wr(`IDX_CTRL, 32'h0000_0000);
      bus(1'b0, `IDX_STATUS, 32'h0);
      chk(rdat & 32'h10, 32'h0000_0000);
      wr(`IDX_PROBE, 32'h0000_040a);
      bus(1'b0, `IDX_STATUS, 32'h0);
      chk(rdat & 32'h60, {25'h0, `CAP_WRITE_ANY, 1'b1, 5'h0});
      wr(`IDX_PROBE, 32'h0000_000a);
      bus(1'b0, `IDX_STATUS, 32'h0);
      chk(rdat & 32'h60, 32'h0000_0060);
      wr(`IDX_PROBE, 32'h0000_100a);
      bus(1'b0, `IDX_STATUS, 32'h0);
      chk(rdat & 32'h20, 32'h0000_0000);
      // timer steps once per toggle of the selected timestamp bit
      wr(`IDX_CTRL, 32'h0000_0001);
      wr(`IDX_TIMER, 32'h0000_0002);
      repeat ((1 << `PREEMPT_RATE) - 4) @(posedge REF_CLK);
      chk({31'h0, TIMER_EXPIRED}, 32'h0);
      repeat (3 * (1 << `PREEMPT_RATE)) @(posedge REF_CLK);
      chk({31'h0, TIMER_EXPIRED}, 32'h1);
      for (int i = 0; i < 8; i++) begin
         wr(`IDX_MISC + i, 32'hffff_ffff);
         wr(`IDX_MISC + `IDX_HIGH + i, 32'hffff_ffff);
      end
      wr(14'h04b0, 32'hffff_ffff);
      rd(14'h04b0, 32'h0000_0000);
      cap_sweep;
      print_verdict;
   end
endmodule // virt_capability_registers_bench
`default_nettype wire

// *** rtl/virt_cap_regs.vh ***
`ifndef VIRT_CAP_REGS_VH
`define VIRT_CAP_REGS_VH

// register indexes; byte address is four times the index
`define IDX_MISC 14'h0485
`define IDX_CR0_F0 14'h0486
`define IDX_CR0_F1 14'h0487
`define IDX_CR4_F0 14'h0488
`define IDX_CR4_F1 14'h0489
`define IDX_ENUM 14'h048a
`define IDX_EPT 14'h048c
// upper 32 bits of each register sit this many words higher
`define IDX_HIGH 14'h0400
// local control and status words
`define IDX_CR0_CAND 14'h04a0
`define IDX_CR4_CAND 14'h04a1
`define IDX_CTRL 14'h04a2
`define IDX_STATUS 14'h04a3
`define IDX_CR0_OUT 14'h04a4
`define IDX_CR4_OUT 14'h04a5
`define IDX_TIMER 14'h04a6
`define IDX_PROBE 14'h04a7
`define IDX_TRACE 14'h04a8

// control word fields
`define CTRL_VIRT 0
`define CTRL_ACT_LO 1
`define CTRL_ACT_HI 2
`define CTRL_SMI_HOLD 3
// status word fields
`define ST_ENTRY_FAIL 0
`define ST_TIMER_RUN 1
`define ST_TIMER_EXP 2
`define ST_GP_FAULT 3
`define ST_SMI_BLOCK 4
`define ST_PROBE_OK 5
`define ST_PROBE_WR 6

// implementation capability values
`define PREEMPT_RATE 5'h05
`define CAP_UNRESTRICTED 1'b1
`define CAP_LMA_STORE 1'b0
`define ACT_STATES 3'h7
`define CAP_TRACE 1'b0
`define CAP_SMBASE_READ 1'b1
`define CR3_TARGETS 8'h04
`define MSR_LIST_N 3'h0
`define CAP_SMI_HOLD 1'b1
`define CAP_WRITE_ANY 1'b0
`define CAP_ZERO_LEN_INJ 1'b1
// arbitrary revision value
`define MONITOR_SEGMENT_REV 32'h0000_0001
`define CR0_FIXED0 64'h0000_0000_0000_0001
`define CR0_FIXED1 64'h0000_0000_0000_ffff
`define CR4_FIXED0 64'h0000_0000_0000_0010
`define CR4_FIXED1 64'h0000_0000_0000_00ff
`define ENUM_MAX_IDX 9'h010
`define CAP_SECONDARY 1'b1
`define CAP_EPT 1'b1
`define CAP_VIRTUAL_PROCESSOR_TAG 1'b1
// raw page-table/tag capabilities, masked to defined bits
`define EPT_CAP_RAW 64'h0000_0f01_0673_4141
`define EPT_CAP_MASK 64'h0000_0f01_06f3_4141
// field type code for exit-information fields
`define FIELD_TYPE_EXIT 2'h1

`endif

// *** rtl/virt_capability_registers.v ***
// How it works
// R1: misc bits 4:0 pick which timestamp bit toggling steps the timer down.
// R2: bit 5 set whenever unrestricted guest is supported; exits copy long mode.
// R3: bits 8:6 list halt, shutdown and startup-wait activity states.
// R4: entry to an unsupported activity state fails; active always allowed.
// R5: bit 14 trace permission; entry clears trace enable, writes fault.
// R6: bit 15 allows system-mgmt base reads in system-mgmt mode.
// R7: bits 24:16 give target count; bit 24 set exactly when 23:16 zero.
// R8: software keeps each model-register list within 512 times N+1.
// R9: bit 28 lets monitor hold bit be set; leaving unblocks unless held.
// R10: bit 29 clear forbids field writes to exit-information fields.
// R11: bit 30 reports zero-length software injection acceptance.
// R12: misc 63:32 revision id; bits 13:9 and 31 read zero.
// R13: in operation fixed-zero ones force one, fixed-one zeros force zero.
// R14: every fixed-zero one bit also reads one in fixed-one register.
// R15: field encoding: width 14:13, type 11:10, index 9:1, access bit 0.
// R16: enumeration returns highest index in 9:1, all else zero.
// R17: page-table caps: execute-only, walk four, uncacheable, write-back.
// R18: bits 16 and 17 allow 2-Mbyte and 1-Gbyte large entries.
// R19: bits 20, 25, 26 report guest-table invalidate and its types.
// R20: bits 21, 22, 23 report dirty flags, exit info, shadow stack.
// R21: bit 32 and bits 43:40 report tag invalidate and its types.
// R22: page-table register reads only with secondary and either feature.
// R23: capability registers are constants; writes leave them unchanged.
`timescale 1ns/100ps
`default_nettype none
`include "virt_cap_regs.vh"

module virt_capability_registers (
   input wire REF_CLK,
   input wire RESETN,
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   output reg [31:0] HRDATA,
   output reg HREADYOUT,
   output reg HRESP,
   output reg VIRT_OP,
   output reg ENTRY_FAIL,
   output reg TIMER_EXPIRED
);

   // bus phase tracking
   wire accept;
   reg wr_pend;
   reg rd_pend;
   reg [13:0] wr_word;
   reg [13:0] rd_word;

   // local state
   reg [31:0] cr0_cand;
   reg [31:0] cr4_cand;
   reg [1:0] act_state;
   reg smi_hold;
   reg smi_blocked;
   reg trace_en;
   reg gp_fault;
   reg [31:0] timestamp_counter;
   reg [31:0] timer;
   reg [31:0] probe;

   // constant capability words
   wire [63:0] misc;
   wire [63:0] cr0_f0;
   wire [63:0] cr0_f1;
   wire [63:0] cr4_f0;
   wire [63:0] cr4_f1;
   wire [63:0] enum_reg;
   wire [63:0] ept_cap;
   wire [8:0] cr3_field;
   wire ept_exists;
   wire [4:0] rate_field;
   wire lma_field;
   wire [2:0] act_field;
   wire trace_field;
   wire smbase_field;
   wire [2:0] list_field;
   wire hold_field;
   wire write_any_field;
   wire zero_len_field;
   wire [31:0] rev_field;
   wire [2:0] act_states;

   // derived logic
   wire [31:0] cr0_out;
   wire [31:0] cr4_out;
   wire [31:0] tsc_next;
   wire tsc_toggle;
   wire timer_step;
   wire timer_zero_hit;
   wire probe_ok;
   wire probe_wr;
   wire wr_ctrl;
   wire wr_status;
   wire [31:0] status;
   reg next_entry_fail;
   reg [31:0] next_rdata;

   assign accept = HSEL & HTRANS[1] & HREADY;

   // count 0 is not encodable; 8'h00 reports 256 targets
   assign cr3_field = {(`CR3_TARGETS == 8'h00), `CR3_TARGETS}; // R7

   // one wire per field so the packing below reads like the map
   assign rate_field = `PREEMPT_RATE; // R1
   assign lma_field = `CAP_LMA_STORE | `CAP_UNRESTRICTED; // R2
   assign act_field = `ACT_STATES; // R3
   assign trace_field = `CAP_TRACE; // R5
   assign smbase_field = `CAP_SMBASE_READ; // R6
   assign list_field = `MSR_LIST_N; // R8
   assign hold_field = `CAP_SMI_HOLD; // R9
   assign write_any_field = `CAP_WRITE_ANY; // R10
   assign zero_len_field = `CAP_ZERO_LEN_INJ; // R11
   assign rev_field = `MONITOR_SEGMENT_REV; // R12
   assign act_states = act_field;

   assign misc = {
      rev_field,       // R12
      1'b0,            // R12
      zero_len_field,  // R11
      write_any_field, // R10
      hold_field,      // R9
      list_field,      // R8
      cr3_field,       // R7
      smbase_field,    // R6
      trace_field,     // R5
      5'h00,           // R12
      act_field,       // R3
      lma_field,       // R2
      rate_field       // R1
   };

   // a fixed-zero bit not allowed by fixed-one is dropped so both agree
   assign cr0_f1 = `CR0_FIXED1;
   assign cr4_f1 = `CR4_FIXED1;
   assign cr0_f0 = `CR0_FIXED0 & `CR0_FIXED1; // R14
   assign cr4_f0 = `CR4_FIXED0 & `CR4_FIXED1; // R14

   assign enum_reg = {54'h0, `ENUM_MAX_IDX, 1'b0}; // R16

   assign ept_exists = `CAP_SECONDARY & (`CAP_EPT | `CAP_VIRTUAL_PROCESSOR_TAG); // R22
   // reserved bits cut by the mask, bits 0,6,8,14 and the large pages
   // R17 R18 R19 R20 R21
   assign ept_cap = ept_exists ? (`EPT_CAP_RAW & `EPT_CAP_MASK) : 64'h0;

   // one slice per control register bit; fixed bits win in operation
   genvar b;
   generate
      for (b = 0; b < 32; b = b + 1) begin : g_force
         assign cr0_out[b] = VIRT_OP ?
            ((cr0_cand[b] | cr0_f0[b]) & cr0_f1[b]) : cr0_cand[b]; // R13
         assign cr4_out[b] = VIRT_OP ?
            ((cr4_cand[b] | cr4_f0[b]) & cr4_f1[b]) : cr4_cand[b]; // R13
      end
   endgenerate

   // timer steps when the chosen counter bit flips on increment
   assign tsc_next = timestamp_counter + 32'h0000_0001;
   assign tsc_toggle = (tsc_next[`PREEMPT_RATE] != timestamp_counter[`PREEMPT_RATE]); // R1
   assign timer_step = VIRT_OP & (timer != 32'h0) & tsc_toggle; // R1
   assign timer_zero_hit = timer_step & (timer == 32'h0000_0001);

   // field encoding probe
   assign probe_ok = (probe[31:15] == 17'h0) & ~probe[12] &
      (probe[9:1] <= `ENUM_MAX_IDX); // R15
   assign probe_wr = probe_ok &
      (`CAP_WRITE_ANY | (probe[11:10] != `FIELD_TYPE_EXIT)); // R10

   assign wr_ctrl = wr_pend & (wr_word == `IDX_CTRL);
   assign wr_status = wr_pend & (wr_word == `IDX_STATUS);

   assign status = {25'h0, probe_wr, probe_ok, smi_blocked, gp_fault,
      TIMER_EXPIRED, timer != 32'h0, ENTRY_FAIL};

   // unsupported activity state makes entry fail
   always @* begin
      case (act_state)
         2'h0: next_entry_fail = 1'b0; // R4
         2'h1: next_entry_fail = ~act_states[0]; // R4
         2'h2: next_entry_fail = ~act_states[1]; // R4
         2'h3: next_entry_fail = ~act_states[2]; // R4
         default: next_entry_fail = 1'b1;
      endcase
   end

   // capability words ignore writes: only local words are decoded
   always @* begin
      case (rd_word)
         `IDX_MISC: next_rdata = misc[31:0]; // R23
         `IDX_MISC + `IDX_HIGH: next_rdata = misc[63:32];
         `IDX_CR0_F0: next_rdata = cr0_f0[31:0];
         `IDX_CR0_F0 + `IDX_HIGH: next_rdata = cr0_f0[63:32];
         `IDX_CR0_F1: next_rdata = cr0_f1[31:0];
         `IDX_CR0_F1 + `IDX_HIGH: next_rdata = cr0_f1[63:32];
         `IDX_CR4_F0: next_rdata = cr4_f0[31:0];
         `IDX_CR4_F0 + `IDX_HIGH: next_rdata = cr4_f0[63:32];
         `IDX_CR4_F1: next_rdata = cr4_f1[31:0];
         `IDX_CR4_F1 + `IDX_HIGH: next_rdata = cr4_f1[63:32];
         `IDX_ENUM: next_rdata = enum_reg[31:0];
         `IDX_ENUM + `IDX_HIGH: next_rdata = enum_reg[63:32];
         `IDX_EPT: next_rdata = ept_cap[31:0];
         `IDX_EPT + `IDX_HIGH: next_rdata = ept_cap[63:32];
         `IDX_CR0_CAND: next_rdata = cr0_cand;
         `IDX_CR4_CAND: next_rdata = cr4_cand;
         `IDX_CTRL: next_rdata = {28'h0, smi_hold, act_state, VIRT_OP};
         `IDX_STATUS: next_rdata = status;
         `IDX_CR0_OUT: next_rdata = cr0_out;
         `IDX_CR4_OUT: next_rdata = cr4_out;
         `IDX_TIMER: next_rdata = timer;
         `IDX_PROBE: next_rdata = probe;
         `IDX_TRACE: next_rdata = {31'h0, trace_en};
         default: next_rdata = 32'h0;
      endcase
   end

   // bus slave: writes zero wait, reads take one wait state so a
   // write in its data phase is visible to the read right behind it
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end else begin
         wr_pend <= accept & HWRITE;
         rd_pend <= accept & ~HWRITE;
         HREADYOUT <= ~(accept & ~HWRITE);
         HRESP <= 1'b0;
      end
   end

   // word index held through the data phase
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         wr_word <= 14'h0;
         rd_word <= 14'h0;
      end else begin
         if (accept) begin
            wr_word <= HADDR[15:2];
            rd_word <= HADDR[15:2];
         end
      end
   end

   // read data holds until the next read completes
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         HRDATA <= 32'h0;
      end else begin
         if (rd_pend) begin
            HRDATA <= next_rdata;
         end
      end
   end

   // candidate control registers and probe
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cr0_cand <= 32'h0;
         cr4_cand <= 32'h0;
         probe <= 32'h0;
         act_state <= 2'h0;
         smi_hold <= 1'b0;
      end else begin
         if (wr_pend & (wr_word == `IDX_CR0_CAND)) begin
            cr0_cand <= HWDATA;
         end
         if (wr_pend & (wr_word == `IDX_CR4_CAND)) begin
            cr4_cand <= HWDATA;
         end
         if (wr_pend & (wr_word == `IDX_PROBE)) begin
            probe <= HWDATA;
         end
         if (wr_ctrl) begin
            act_state <= HWDATA[`CTRL_ACT_HI:`CTRL_ACT_LO];
            smi_hold <= HWDATA[`CTRL_SMI_HOLD] & `CAP_SMI_HOLD; // R9
         end
      end
   end

   // entry check result lags the state by one edge
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ENTRY_FAIL <= 1'b0;
      end else begin
         ENTRY_FAIL <= VIRT_OP & next_entry_fail; // R4
      end
   end

   // operation state
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         VIRT_OP <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            VIRT_OP <= HWDATA[`CTRL_VIRT];
         end
      end
   end

   // entering clears trace when tracing is not allowed
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         trace_en <= 1'b0;
      end else begin
         if (wr_ctrl & ~VIRT_OP & HWDATA[`CTRL_VIRT] & ~`CAP_TRACE) begin
            trace_en <= 1'b0; // R5
         end else if (wr_pend & (wr_word == `IDX_TRACE) &
               ~(VIRT_OP & ~`CAP_TRACE)) begin
            trace_en <= HWDATA[0];
         end
      end
   end

   // fault is sticky; a new fault wins over its clear
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         gp_fault <= 1'b0;
      end else begin
         if (wr_pend & (wr_word == `IDX_TRACE) & VIRT_OP & ~`CAP_TRACE) begin
            gp_fault <= 1'b1; // R5
         end else if (wr_status & HWDATA[`ST_GP_FAULT]) begin
            gp_fault <= 1'b0;
         end
      end
   end

   // interrupts stay blocked after leaving while the hold bit is set
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         smi_blocked <= 1'b0;
      end else begin
         if (wr_ctrl & ~VIRT_OP & HWDATA[`CTRL_VIRT]) begin
            smi_blocked <= 1'b1;
         end else if (wr_ctrl & VIRT_OP & ~HWDATA[`CTRL_VIRT] &
               ~smi_hold) begin
            smi_blocked <= 1'b0; // R9
         end
      end
   end

   // preemption timer; only free-running counter bits feed it
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         timestamp_counter <= 32'h0;
      end else begin
         timestamp_counter <= tsc_next;
      end
   end

   // a software load wins over a step in the same cycle
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         timer <= 32'h0;
      end else begin
         if (wr_pend & (wr_word == `IDX_TIMER)) begin
            timer <= HWDATA;
         end else if (timer_step) begin
            timer <= timer - 32'h0000_0001; // R1
         end
      end
   end

   // sticky expiry; the set wins over a clear in the same cycle
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         TIMER_EXPIRED <= 1'b0;
      end else begin
         if (timer_zero_hit) begin
            TIMER_EXPIRED <= 1'b1;
         end else if (wr_status & HWDATA[`ST_TIMER_EXP]) begin
            TIMER_EXPIRED <= 1'b0;
         end
      end
   end

endmodule // virt_capability_registers
`default_nettype wire
